// File: rtl/cfg_port_pkg.sv
// constants, register map and carrier types of the configuration port host
// assumes one core clock of 125 MHz and a device that drives busy, init and done
//
// What this block does
// - data bus is eight bits, two-way; line zero is the byte's top bit
// - direction select low means host writes, high means device drives data
// - a byte refused while busy is high is presented again afterwards
// - direction set before select; changed only while deselected or clock quiet
// - host watches busy in readback and encrypted loads; busy byte is refused
// - without busy handshake the clock stays at or below 50 MHz
// - done rises during startup; host may need to keep clocking
// - after configuration release port select first, then direction select
// - with the clock halted direction may change if restored before next edge
// - shared bus: own port select per device, all other lines common
package cfg_port_pkg;

  // timing
  localparam int CORE_PERIOD_NS = 8;
  localparam int NOHS_MAX_MHZ = 50;
  localparam int NOHS_MIN_PERIOD_NS = 1000 / NOHS_MAX_MHZ;
  localparam int NOHS_MIN_HALF = (NOHS_MIN_PERIOD_NS + 2 * CORE_PERIOD_NS - 1)
                                 / (2 * CORE_PERIOD_NS);
  localparam int PROG_PULSE_NS = 300;
  localparam int PROG_CYC = (PROG_PULSE_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int STARTUP_MIN_EDGES = 8;
  localparam int STARTUP_MAX_EDGES = 255;
  localparam int HALF_DIV_DEFAULT = 10;

  // register map, byte addresses
  localparam int ADDR_W = 5;
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_CMD = 5'h04;
  localparam logic [4:0] REG_DATA = 5'h08;
  localparam logic [4:0] REG_STATUS = 5'h0c;
  localparam logic [4:0] REG_COUNT = 5'h10;

  // field positions
  localparam int CTRL_HS_BIT = 0;
  localparam int CTRL_HOLDINIT_BIT = 1;
  localparam int CMD_PROG_BIT = 0;
  localparam int CMD_READ_BIT = 1;
  localparam int CMD_FINISH_BIT = 2;

  // reset values
  localparam logic CTRL_HS_RESET = 1'h1;
  localparam logic CTRL_HOLDINIT_RESET = 1'h0;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_PROG = 3'h1,
    S_WAITI = 3'h3,
    S_READY = 3'h2,
    S_WRITE = 3'h6,
    S_STARTUP = 3'h7,
    S_DONE = 3'h5,
    S_READ = 3'h4
  } hostState_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } regReq_t;

  typedef struct packed {
    logic [21:0] zero;
    logic crcErr;
    logic timeout;
    logic rbValid;
    logic txPending;
    logic done;
    logic busy;
    logic init;
    hostState_t state;
  } status_t;

  // data[7] is line zero, the top bit of each byte
  typedef struct packed {
    logic [7:0] data;
    logic busy;
    logic init;
    logic done;
  } pinsIn_t;

  typedef struct packed {
    logic programResetN;
    logic configClock;
    logic portSelectN;
    logic readWriteSelectN;
    logic [7:0] dataOut;
    logic dataOeN;
    logic initOut;
    logic initOeN;
  } pinsOut_t;

endpackage

// File: rtl/cfg_pin_sync.sv
// two-stage synchroniser for a group of pin inputs
// assumes the pins change at most once per few core clocks
`timescale 1ns/1ps
module cfg_pin_sync #(
  parameter int W = 11
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } syncRegs_t;

  syncRegs_t r;
  syncRegs_t n;

  // first stage feeds only the second stage
  always_comb begin
    n.s1 = d;
    n.s2 = r.s1;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      r <= '0;
    end else if (ce) begin
      r <= n;
    end
  end

  assign q = r.s2;
endmodule

// File: rtl/cfg_clock_divider.sv
// divider that makes the configuration clock from the core clock
// assumes HALF core cycles per half period; ticks lead each clock edge by one cycle
`timescale 1ns/1ps
module cfg_clock_divider #(
  parameter int HALF = 10
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic run,
  output logic configClock,
  output logic riseTick,
  output logic fallTick
);
  localparam int CW = 16;

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic clk;
  } divRegs_t;

  divRegs_t r;
  divRegs_t n;

  // a high phase always completes, so stopping never leaves a short pulse
  always_comb begin
    n = r;
    if (r.clk || run) begin
      if (r.cnt == CW'(HALF - 1)) begin
        n.cnt = '0;
        n.clk = !r.clk;
      end else begin
        n.cnt = r.cnt + 16'h0001;
      end
    end else begin
      n.cnt = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      r <= '0;
    end else if (ce) begin
      r <= n;
    end
  end

  assign configClock = r.clk;
  assign riseTick = run && !r.clk && (r.cnt == CW'(HALF - 1));
  assign fallTick = r.clk && (r.cnt == CW'(HALF - 1));
endmodule

// File: rtl/cfg_port_host.sv
// host controller that loads and reads back a device over its byte-wide config port
// assumes the device samples on rising clock edges and a bench resolving the pin enables
`timescale 1ns/1ps
module cfg_port_host #(
  parameter int HALF_DIV = cfg_port_pkg::HALF_DIV_DEFAULT,
  parameter int STARTUP_MAX = cfg_port_pkg::STARTUP_MAX_EDGES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire cfg_port_pkg::regReq_t regReq,
  output logic [31:0] rdData,
  input wire cfg_port_pkg::pinsIn_t pinsIn,
  output cfg_port_pkg::pinsOut_t pinsOut
);
  // without handshake the clock must not pass the upper rate
  localparam int HALF_EFF = (HALF_DIV < cfg_port_pkg::NOHS_MIN_HALF) ?
                            cfg_port_pkg::NOHS_MIN_HALF : HALF_DIV;

  typedef struct packed {
    cfg_port_pkg::hostState_t state;
    logic [7:0] cnt;
    logic hsEn;
    logic holdInit;
    logic [7:0] txByte;
    logic txPending;
    logic [7:0] rbByte;
    logic rbValid;
    logic rbReq;
    logic finReq;
    logic crcErr;
    logic timeout;
    logic [15:0] bytesSent;
    logic [31:0] rdData;
    cfg_port_pkg::pinsOut_t pins;
  } hostRegs_t;

  hostRegs_t r;
  hostRegs_t n;
  cfg_port_pkg::pinsIn_t pinsS;
  cfg_port_pkg::status_t stat;
  logic clkRun;
  logic divClk;
  logic riseTick;
  logic fallTick;
  logic progCmd;
  logic linkActive;

  // register-port decode used for every write target
  function automatic logic isWrite(cfg_port_pkg::regReq_t q, logic [4:0] a);
    return q.wr && (q.addr == a);
  endfunction

  // every device pin passes two flops before any logic looks at it
  cfg_pin_sync #(
    .W($bits(cfg_port_pkg::pinsIn_t))
  ) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .d(pinsIn),
    .q(pinsS)
  );

  // clock runs from init wait until startup ends; it is quiet in reset and when done
  assign clkRun = !(r.state inside {cfg_port_pkg::S_IDLE, cfg_port_pkg::S_PROG,
                                    cfg_port_pkg::S_DONE});

  cfg_clock_divider #(
    .HALF(HALF_EFF)
  ) u_div (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .run(clkRun),
    .configClock(divClk),
    .riseTick(riseTick),
    .fallTick(fallTick)
  );

  assign progCmd = isWrite(regReq, cfg_port_pkg::REG_CMD) &&
                   regReq.wdata[cfg_port_pkg::CMD_PROG_BIT];
  assign linkActive = !(r.state inside {cfg_port_pkg::S_IDLE, cfg_port_pkg::S_PROG,
                                        cfg_port_pkg::S_WAITI});

  // status word as software sees it
  always_comb begin
    stat = '0;
    stat.crcErr = r.crcErr;
    stat.timeout = r.timeout;
    stat.rbValid = r.rbValid;
    stat.txPending = r.txPending;
    stat.done = pinsS.done;
    stat.busy = pinsS.busy;
    stat.init = pinsS.init;
    stat.state = r.state;
  end

  // next state: read clears first, link sequencing next, register writes last
  always_comb begin
    n = r;
    n.rdData = 32'h0000_0000;
    // reads answer one cycle later; reading data consumes the readback byte
    if (regReq.rd) begin
      case (regReq.addr)
        cfg_port_pkg::REG_CTRL: begin
          n.rdData[cfg_port_pkg::CTRL_HS_BIT] = r.hsEn;
          n.rdData[cfg_port_pkg::CTRL_HOLDINIT_BIT] = r.holdInit;
        end
        cfg_port_pkg::REG_DATA: begin
          n.rdData[7:0] = r.rbByte;
          n.rbValid = 1'b0;
        end
        cfg_port_pkg::REG_STATUS: begin
          n.rdData = stat;
        end
        cfg_port_pkg::REG_COUNT: begin
          n.rdData[15:0] = r.bytesSent;
        end
        default: begin
          n.rdData = 32'h0000_0000;
        end
      endcase
    end
    // init dropping after it rose means the device found a checksum error
    if (linkActive && !pinsS.init) begin
      n.crcErr = 1'b1;
    end
    case (r.state)
      cfg_port_pkg::S_IDLE: begin
        n.pins.portSelectN = 1'b1;
      end
      // program reset held low for a fixed pulse, then released
      cfg_port_pkg::S_PROG: begin
        n.pins.programResetN = 1'b0;
        n.cnt = r.cnt + 8'h01;
        if (r.cnt == 8'(cfg_port_pkg::PROG_CYC - 1)) begin
          n.pins.programResetN = 1'b1;
          n.cnt = 8'h00;
          n.state = cfg_port_pkg::S_WAITI;
        end
      end
      // nothing is selected until init has risen; the device captures mode pins then
      cfg_port_pkg::S_WAITI: begin
        if (pinsS.init) begin
          n.state = cfg_port_pkg::S_READY;
        end
      end
      // outputs only move on falling edges, and direction only while deselected
      cfg_port_pkg::S_READY: begin
        if (fallTick) begin
          if (r.finReq) begin
            n.finReq = 1'b0;
            n.cnt = 8'h00;
            n.state = cfg_port_pkg::S_STARTUP;
          end else if (r.rbReq) begin
            if (r.pins.readWriteSelectN) begin
              n.pins.portSelectN = 1'b0;
              n.cnt = 8'h00;
              n.state = cfg_port_pkg::S_READ;
            end else begin
              n.pins.readWriteSelectN = 1'b1;
            end
          end else if (r.txPending) begin
            if (!r.pins.readWriteSelectN) begin
              n.pins.portSelectN = 1'b0;
              n.pins.dataOut = r.txByte;
              n.pins.dataOeN = 1'b0;
              n.state = cfg_port_pkg::S_WRITE;
            end else begin
              n.pins.readWriteSelectN = 1'b0;
            end
          end
        end
      end
      // one byte per rising edge; with handshake on, a byte seen with busy high stays on the bus
      cfg_port_pkg::S_WRITE: begin
        if (riseTick && !(r.hsEn && pinsS.busy)) begin
          n.txPending = 1'b0;
          n.bytesSent = r.bytesSent + 16'h0001;
        end
        if (fallTick) begin
          if (r.txPending) begin
            n.pins.dataOut = r.txByte;
          end else begin
            n.pins.portSelectN = 1'b1;
            n.pins.dataOeN = 1'b1;
            n.state = cfg_port_pkg::S_READY;
          end
        end
      end
      // the first edge after select only wakes the device; later busy low marks data
      cfg_port_pkg::S_READ: begin
        if (riseTick) begin
          n.cnt = 8'h01;
          if (r.cnt != 8'h00 && !pinsS.busy && r.rbReq) begin
            n.rbByte = pinsS.data;
            n.rbValid = 1'b1;
            n.rbReq = 1'b0;
          end
        end
        if (fallTick && !r.rbReq) begin
          n.pins.portSelectN = 1'b1;
          n.state = cfg_port_pkg::S_READY;
        end
      end
      // keep clocking until the minimum edges passed and done is seen, or STARTUP_MAX edges passed without it
      cfg_port_pkg::S_STARTUP: begin
        if (fallTick) begin
          n.pins.readWriteSelectN = 1'b0;
        end
        if (riseTick) begin
          n.cnt = r.cnt + 8'h01;
          if (r.cnt >= 8'(cfg_port_pkg::STARTUP_MIN_EDGES - 1) && pinsS.done) begin
            n.state = cfg_port_pkg::S_DONE;
          end else if (r.cnt >= 8'(STARTUP_MAX - 1)) begin
            n.timeout = 1'b1;
            n.state = cfg_port_pkg::S_DONE;
          end
        end
      end
      cfg_port_pkg::S_DONE: begin
        n.pins.portSelectN = 1'b1;
      end
      default: begin
        n.state = cfg_port_pkg::S_IDLE;
      end
    endcase
    // software writes; a new byte may follow the instant the last one was taken
    if (isWrite(regReq, cfg_port_pkg::REG_CTRL)) begin
      n.hsEn = regReq.wdata[cfg_port_pkg::CTRL_HS_BIT];
      n.holdInit = regReq.wdata[cfg_port_pkg::CTRL_HOLDINIT_BIT];
    end
    if (isWrite(regReq, cfg_port_pkg::REG_DATA) && !n.txPending && linkActive) begin
      n.txByte = regReq.wdata[7:0];
      n.txPending = 1'b1;
    end
    if (isWrite(regReq, cfg_port_pkg::REG_CMD) && linkActive) begin
      if (regReq.wdata[cfg_port_pkg::CMD_READ_BIT]) begin
        n.rbReq = 1'b1;
      end
      if (regReq.wdata[cfg_port_pkg::CMD_FINISH_BIT]) begin
        n.finReq = 1'b1;
      end
    end
    // program restarts the link from any state; ctrl bits and readback byte are kept
    if (progCmd) begin
      n.state = cfg_port_pkg::S_PROG;
      n.cnt = 8'h00;
      n.pins.programResetN = 1'b0;
      n.pins.portSelectN = 1'b1;
      n.pins.readWriteSelectN = 1'b0;
      n.pins.dataOeN = 1'b1;
      n.txPending = 1'b0;
      n.rbReq = 1'b0;
      n.finReq = 1'b0;
      n.crcErr = 1'b0;
      n.timeout = 1'b0;
      n.bytesSent = 16'h0000;
    end
    // init is held low only while waiting, to delay the device's start
    n.pins.initOut = 1'b0;
    n.pins.initOeN = !(n.holdInit && (n.state == cfg_port_pkg::S_WAITI));
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      r <= '0;
      r.state <= cfg_port_pkg::S_IDLE;
      r.hsEn <= cfg_port_pkg::CTRL_HS_RESET;
      r.holdInit <= cfg_port_pkg::CTRL_HOLDINIT_RESET;
      r.pins.programResetN <= 1'b1;
      r.pins.portSelectN <= 1'b1;
      r.pins.dataOeN <= 1'b1;
      r.pins.initOeN <= 1'b1;
    end else if (ce) begin
      r <= n;
    end
  end

  // the clock pin comes straight from the divider flop
  always_comb begin
    pinsOut = r.pins;
    pinsOut.configClock = divClk;
  end
  assign rdData = r.rdData;

  // checks on the pin sequencing
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n || !ce);

  logic inDone;
  assign inDone = (r.state == cfg_port_pkg::S_DONE);

  sequence s_progLow;
    (!r.pins.programResetN) [*8];
  endsequence

  property p_rdwrOnlyDeselected;
    $changed(r.pins.readWriteSelectN) |-> r.pins.portSelectN && $past(r.pins.portSelectN);
  endproperty
  a_rdwrOnlyDeselected: assert property (p_rdwrOnlyDeselected)
    else $error("direction select changed while selected");

  property p_driveOnlySelectedWrite;
    !r.pins.dataOeN |-> !r.pins.portSelectN && !r.pins.readWriteSelectN;
  endproperty
  a_driveOnlySelectedWrite: assert property (p_driveOnlySelectedWrite)
    else $error("data driven while not selected for write");

  property p_noSelectBeforeInit;
    r.state inside {cfg_port_pkg::S_PROG, cfg_port_pkg::S_WAITI} |-> r.pins.portSelectN;
  endproperty
  a_noSelectBeforeInit: assert property (p_noSelectBeforeInit)
    else $error("port selected before init rose");

  property p_readyOnInit;
    r.state == cfg_port_pkg::S_WAITI && pinsS.init && !progCmd
      |=> r.state == cfg_port_pkg::S_READY;
  endproperty
  a_readyOnInit: assert property (p_readyOnInit)
    else $error("init high did not open the port");

  property p_progPulse;
    $fell(r.pins.programResetN) && !progCmd |-> s_progLow ##31 r.pins.programResetN;
  endproperty
  a_progPulse: assert property (p_progPulse)
    else $error("program reset pulse has wrong length");

  property p_busyRefused;
    r.state == cfg_port_pkg::S_WRITE && riseTick && r.hsEn && pinsS.busy && !progCmd
      |=> r.txPending && $stable(r.bytesSent);
  endproperty
  a_busyRefused: assert property (p_busyRefused)
    else $error("byte counted as taken while busy");

  property p_byteTaken;
    r.state == cfg_port_pkg::S_WRITE && riseTick && !(r.hsEn && pinsS.busy) && !progCmd
      |=> r.bytesSent == $past(r.bytesSent) + 16'h0001;
  endproperty
  a_byteTaken: assert property (p_byteTaken)
    else $error("byte on a free edge not taken");

  property p_dataHeld;
    !r.pins.dataOeN && !fallTick |=> $stable(r.pins.dataOut);
  endproperty
  a_dataHeld: assert property (p_dataHeld)
    else $error("data changed away from a falling edge");

  property p_startupLength;
    $rose(inDone) && !r.timeout |-> r.cnt >= 8'(cfg_port_pkg::STARTUP_MIN_EDGES);
  endproperty
  a_startupLength: assert property (p_startupLength)
    else $error("startup ended too early");

  property p_readCapture;
    r.state == cfg_port_pkg::S_READ && riseTick && r.cnt != 8'h00 && !pinsS.busy &&
      r.rbReq && !progCmd |=> r.rbValid && r.rbByte == $past(pinsS.data);
  endproperty
  a_readCapture: assert property (p_readCapture)
    else $error("readback byte not captured");
endmodule

// File: verification/cfg_device_model.sv
// behavioural model of the device behind the byte-wide configuration port
// assumes the bench resolves the shared data, init and done wires
`timescale 1ns/1ps
module cfg_device_model #(
  parameter int LOAD_BYTES = 3,
  parameter int INIT_DELAY = 50,
  parameter logic [7:0] READ_BYTE = 8'hc3
) (
  input wire logic core_clk,
  input wire logic programResetN,
  input wire logic configClock,
  input wire logic portSelectN,
  input wire logic readWriteSelectN,
  input wire logic [7:0] dataIn,
  input wire logic slow,
  output logic [7:0] dataOut,
  output logic busy,
  output logic initDrv,
  output logic done,
  output int rxCount,
  output int abortCount
);
  logic [7:0] rxMem [0:15];
  int initWait = 0;
  int edgeCnt = 0;
  int startEdges = 0;
  logic lastDir;
  logic floatBit = 1'b0;
  logic refuse;

  // init held low through a program pulse and a settling delay, then left to the pull-up
  always @(posedge core_clk) begin
    floatBit <= ~floatBit;
    if (!programResetN) begin
      initWait <= 0;
    end else if (initWait < INIT_DELAY) begin
      initWait <= initWait + 1;
    end
  end
  assign initDrv = programResetN && initWait >= INIT_DELAY;

  // first selected edge is a busy one in slow mode and for readback
  assign refuse = edgeCnt == 0 && (slow || readWriteSelectN);
  // released lines toggle every cycle so a stale value is never mistaken for data
  assign busy = portSelectN ? floatBit : refuse;
  assign dataOut = (!portSelectN && readWriteSelectN && edgeCnt > 0) ? READ_BYTE
                   : {4{floatBit, ~floatBit}};

  // port logic runs only on the configuration clock, program resets it at once
  always @(posedge configClock or negedge programResetN) begin
    if (!programResetN) begin
      rxCount <= 0;
      abortCount <= 0;
      done <= 1'b0;
      edgeCnt <= 0;
      startEdges <= 0;
    end else if (initDrv && !portSelectN) begin
      edgeCnt <= edgeCnt + 1;
      lastDir <= readWriteSelectN;
      if (edgeCnt > 0 && readWriteSelectN != lastDir) begin
        abortCount <= abortCount + 1;
      end
      if (!readWriteSelectN && !refuse) begin
        rxMem[rxCount[3:0]] <= dataIn;
        rxCount <= rxCount + 1;
      end
    end else begin
      edgeCnt <= 0;
      if (rxCount >= LOAD_BYTES) begin
        startEdges <= startEdges + 1;
      end
      if (startEdges >= 3) begin
        done <= 1'b1;
      end
    end
  end
endmodule

// File: verification/parallel_config_port_loader_tb.sv
// self-checking bench for the configuration port host against a device model
// assumes package, host and model files are compiled before this one
`timescale 1ns/1ps
module parallel_config_port_loader_tb;
  localparam logic [7:0] RB = 8'hc3;
  logic core_clk;
  logic rst_n;
  logic ce;
  logic slow;
  cfg_port_pkg::regReq_t regReq;
  logic [31:0] rdData;
  cfg_port_pkg::pinsIn_t pinsIn;
  cfg_port_pkg::pinsOut_t pinsOut;
  logic [7:0] devData;
  logic devBusy;
  logic devInit;
  logic devDone;
  int rxCount;
  int abortCount;
  int clkEdges = 0;
  int n_mismatch = 0;
  int checks = 0;
  logic [31:0] v;

  // host owns the data bus while its enable is low; init is open drain with a pull-up
  assign pinsIn = {pinsOut.dataOeN ? devData : pinsOut.dataOut, devBusy,
                   devInit & pinsOut.initOeN, devDone === 1'b1};

  cfg_port_host #(.HALF_DIV(10), .STARTUP_MAX(20)) dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .regReq(regReq),
    .rdData(rdData), .pinsIn(pinsIn), .pinsOut(pinsOut));

  cfg_device_model #(.LOAD_BYTES(3), .READ_BYTE(RB)) dev_u (
    .core_clk(core_clk), .programResetN(pinsOut.programResetN),
    .configClock(pinsOut.configClock), .portSelectN(pinsOut.portSelectN),
    .readWriteSelectN(pinsOut.readWriteSelectN), .dataIn(pinsIn.data), .slow(slow),
    .dataOut(devData), .busy(devBusy), .initDrv(devInit), .done(devDone),
    .rxCount(rxCount), .abortCount(abortCount));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // edges of the link clock, for the startup length
  always @(posedge pinsOut.configClock) clkEdges++;

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic regWrite(input logic [4:0] addr, input logic [31:0] data);
    @(posedge core_clk);
    regReq <= '{rd: 1'b0, wr: 1'b1, addr: addr, wdata: data};
    @(posedge core_clk);
    regReq.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic regRead(input logic [4:0] addr, output logic [31:0] data);
    @(posedge core_clk);
    regReq <= '{rd: 1'b1, wr: 1'b0, addr: addr, wdata: 32'h0000_0000};
    @(posedge core_clk);
    regReq.rd <= 1'b0;
    #1 data = rdData;
  endtask

  // poll status under a bound so a stuck host cannot hang the run
  task automatic waitStatus(input logic [31:0] mask, input logic [31:0] want, input string what);
    for (int i = 0; i < 3000; i++) begin
      regRead(cfg_port_pkg::REG_STATUS, v);
      if ((v & mask) === want) break;
    end
    check(what, v & mask, want);
  endtask

  task automatic testReset;
    regRead(cfg_port_pkg::REG_STATUS, v);
    check("idle state", v & 32'h0000_0007, 32'h0000_0000);
    regRead(cfg_port_pkg::REG_CTRL, v);
    check("ctrl reset", v, 32'h0000_0001);
    regRead(5'h14, v);
    check("unmapped", v, 32'h0000_0000);
    check("select idle", pinsOut.portSelectN, 32'h0000_0001);
    check("data released", pinsOut.dataOeN, 32'h0000_0001);
  endtask

  task automatic testProgram(input string what);
    int n;
    n = 0;
    regWrite(cfg_port_pkg::REG_CMD, 32'h0000_0001);
    // let the command's edge settle, so the pulse is counted from its first cycle
    #1;
    for (int i = 0; i < 20 && pinsOut.programResetN; i++) begin
      @(posedge core_clk);
      #1;
    end
    while (!pinsOut.programResetN && n < 100) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check(what, n, cfg_port_pkg::PROG_CYC);
    waitStatus(32'h0000_0007, 32'h0000_0002, "ready");
    regRead(cfg_port_pkg::REG_COUNT, v);
    check("count cleared", v & 32'h0000_ffff, 32'h0000_0000);
    check("no early abort", abortCount, 32'h0000_0000);
  endtask

  task automatic testRead;
    regWrite(cfg_port_pkg::REG_CMD, 32'h0000_0002);
    waitStatus(32'h0000_0080, 32'h0000_0080, "readback valid");
    regRead(cfg_port_pkg::REG_DATA, v);
    check("read byte", v & 32'h0000_00ff, {24'h00_0000, RB});
  endtask

  // first byte goes straight in, later ones meet a busy first edge
  task automatic testWrite;
    logic [7:0] bytes [3] = '{8'h5a, 8'ha5, 8'h81};
    for (int i = 0; i < 3; i++) begin
      slow <= (i != 0);
      regWrite(cfg_port_pkg::REG_DATA, {24'h00_0000, bytes[i]});
      waitStatus(32'h0000_0040, 32'h0000_0000, "byte taken");
      // closing the burst makes the next byte meet a fresh, busy first edge
      waitStatus(32'h0000_0007, 32'h0000_0002, "burst closed");
      repeat (2) @(posedge core_clk);
      check("byte seen", dev_u.rxMem[i], bytes[i]);
    end
    regRead(cfg_port_pkg::REG_COUNT, v);
    check("count", v & 32'h0000_ffff, 32'h0000_0003);
    check("device count", rxCount, 32'h0000_0003);
    check("no abort", abortCount, 32'h0000_0000);
  endtask

  task automatic testFinish;
    int e;
    e = clkEdges;
    regWrite(cfg_port_pkg::REG_CMD, 32'h0000_0004);
    waitStatus(32'h0000_0027, 32'h0000_0025, "startup done");
    check("startup edges", clkEdges - e >= 8, 32'h0000_0001);
    check("select released", pinsOut.portSelectN, 32'h0000_0001);
    check("direction low", pinsOut.readWriteSelectN, 32'h0000_0000);
    check("no abort", abortCount, 32'h0000_0000);
  endtask

  // holding init low keeps the host waiting; letting it go opens the port
  task automatic testHoldInit;
    regWrite(cfg_port_pkg::REG_CTRL, 32'h0000_0003);
    regRead(cfg_port_pkg::REG_CTRL, v);
    check("ctrl written", v, 32'h0000_0003);
    regWrite(cfg_port_pkg::REG_CMD, 32'h0000_0001);
    repeat (120) @(posedge core_clk);
    regRead(cfg_port_pkg::REG_STATUS, v);
    check("init held", v & 32'h0000_000f, 32'h0000_0003);
    check("init pulled", pinsOut.initOeN, 32'h0000_0000);
    regWrite(cfg_port_pkg::REG_CTRL, 32'h0000_0001);
    waitStatus(32'h0000_0007, 32'h0000_0002, "init released");
  endtask

  initial begin
    #400000;
    n_mismatch++;
    test_done();
  end

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    slow = 1'b0;
    regReq = '0;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    testReset();
    testProgram("program pulse");
    testRead();
    testWrite();
    testFinish();
    testHoldInit();
    testProgram("second program pulse");
    test_done();
  end
endmodule
